/* File: core/port_config_cfg.svh */
`ifndef PORT_CONFIG_CFG_SVH
`define PORT_CONFIG_CFG_SVH

// Register indices on the plain register port.
`define REG_GENERAL_CTRL    5'h00
`define REG_SERVICE_REQ     5'h01
`define REG_PORT_A_DIR      5'h02
`define REG_PORT_B_DIR      5'h03
`define REG_PORT_C_DIR      5'h04
`define REG_VECTOR_BASE     5'h05
`define REG_PORT_A_CTRL     5'h06
`define REG_PORT_B_CTRL     5'h07
`define REG_LATCH_STATUS    5'h08

// Reset values.
`define RST_ZERO            8'h00
`define RST_VECTOR          8'h0f

// General control fields.
`define GC_MODE_HI          7
`define GC_MODE_LO          6
`define GC_PAIR34_BIT       5
`define GC_PAIR12_BIT       4

// Service request fields.
`define SR_USED_MASK        8'h7f
`define SR_PINSEL_HI        4
`define SR_PINSEL_LO        3
`define SR_PRIO_HI          2
`define SR_PRIO_LO          0

// Port control fields.
`define PC_SUB_HI           7
`define PC_SUB_LO           6
`define PC_LINE_HI          5
`define PC_LINE_LO          3
`define PC_IRQ_BIT          2
`define PC_SVC_BIT          1
`define PC_STAT_BIT         0

// Vector register keeps only its upper six bits.
`define VEC_MASK            8'hfc

`endif

/* File: core/port_config_pkg.sv */
package port_config_pkg;

    typedef enum logic [1:0] {
        MODE_UNI8  = 2'h0,
        MODE_UNI16 = 2'h1,
        MODE_BID8  = 2'h2,
        MODE_BID16 = 2'h3
    } port_mode_type;

    typedef enum logic [2:0] {
        LINE_STATUS_IN  = 3'h1,
        LINE_NEGATED    = 3'h2,
        LINE_ASSERTED   = 3'h4
    } line_kind_type;

    // Decoded behaviour of one controlled handshake line.
    typedef struct packed {
        logic out_en;
        logic level;
        logic interlocked;
        logic pulsed;
        logic output_type;
    } line_ctrl_type;

    // Fill state of the output latches of one port.
    typedef struct packed {
        logic initial_full;
        logic final_full;
    } latch_state_type;

    typedef struct packed {
        logic [7:0] general;
        logic [7:0] service;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
        logic [7:0] vector;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] rdata;
    } regs_type;

endpackage

/* File: core/port_config.sv */
// Functional notes
// - Pin select routes pins five, six functions.
// - Priority field orders four status flags.
// - Port A direction bit: 0 in, 1 out.
// - Port A direction ignored in mode 3.
// - Reset clears port A direction.
// - Port B direction ignored modes 2, 3.
// - Port C direction per pin, all modes.
// - Reset clears port C direction.
// - Vector keeps six bits, low two zero.
// - Vector reads 0F until first write.
// - Normal vector read has no side effect.
// - Port A control field layout, reset zero.
// - Enable bits gate interrupts and DMA requests.
// - Mode 0 submodes 00/01 line control.
// - Submode 1X and mode 1: static line.
// - Mode 0 sub 01 flag one from A latches.
// - Modes 2, 3 line always handshake output.
// - Mode 2 flag one from B latches.
// - Mode 3 flag one from all latches.
// - Port B control mirrors A, no read effect.
// - Mode field selects four port modes.
// - Pair enables at bits five and four.
`include "port_config_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module port_config (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_i,
    input  wire logic [4:0]                    addr_i,
    input  wire logic [7:0]                    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [7:0]                    rdata_o,
    input  wire logic [3:0]                    status_flags_i,
    input  wire logic [3:0]                    latch_full_i,
    output logic      [1:0]                    port_mode_o,
    output logic                               pair_one_two_enable_o,
    output logic                               pair_three_four_enable_o,
    output logic      [7:0]                    port_a_dir_eff_o,
    output logic      [7:0]                    port_b_dir_eff_o,
    output logic      [7:0]                    port_c_dir_o,
    output logic                               port_c_pin_five_irq_o,
    output logic                               port_c_pin_six_ack_o,
    output logic      [1:0]                    service_select_o,
    output logic      [7:0]                    prio_order_o,
    output logic      [5:0]                    vector_upper_o,
    output port_config_pkg::line_ctrl_type     line_2_ctrl_o,
    output port_config_pkg::line_ctrl_type     line_4_ctrl_o,
    output logic                               line_1_service_en_o,
    output logic                               line_2_irq_en_o,
    output logic                               line_3_service_en_o,
    output logic                               line_4_irq_en_o,
    output logic                               status_flag_1_o,
    output logic                               status_flag_3_o
);

    port_config_pkg::regs_type  r_q;
    port_config_pkg::regs_type  r_d;
    logic                       vec_written_q;
    logic                       vec_written_d;

    // Decodes a controlled line from its three control bits, the mode and submode.
    function automatic port_config_pkg::line_ctrl_type line_decode(input logic [2:0] c,
                                                                    input logic [1:0] mode,
                                                                    input logic [1:0] sub);
        port_config_pkg::line_ctrl_type l;
        l = '0;
        if (mode[1]) begin
            l.out_en      = 1'b1;
            l.output_type = 1'b1;
            l.interlocked = ~c[0];
            l.pulsed      = c[0];
        end else if (mode == 2'h0 && !sub[1] && c[2] && c[1]) begin
            l.out_en      = 1'b1;
            l.output_type = sub[0];
            l.interlocked = ~c[0];
            l.pulsed      = c[0];
        end else if (c[2]) begin
            l.out_en = 1'b1;
            l.level  = c[0];
        end
        return l;
    endfunction

    // Returns the flag numbers 1 to 4, two bits each as index 0 to 3, highest first.
    function automatic logic [7:0] prio_decode(input logic [2:0] p);
        logic [1:0] hi0;
        logic [1:0] hi1;
        logic [1:0] lo0;
        logic [1:0] lo1;
        hi0 = p[2] ? {1'b1, p[1]} : {1'b0, p[0]};
        hi1 = p[2] ? {1'b1, ~p[1]} : {1'b0, ~p[0]};
        lo0 = p[2] ? {1'b0, p[0]} : {1'b1, p[1]};
        lo1 = p[2] ? {1'b0, ~p[0]} : {1'b1, ~p[1]};
        return {hi0, hi1, lo0, lo1};
    endfunction

    // Flag one or three over the latches in use_mask: any of them free, or all of them empty.
    function automatic logic fill_flag(input logic both_empty, input logic [3:0] full, input logic [3:0] use_mask);
        logic [3:0] f;
        f = full & use_mask;
        return both_empty ? (f == 4'h0) : (f != use_mask);
    endfunction

    always_comb begin
        r_d           = r_q;
        vec_written_d = vec_written_q;
        r_d.rdata     = `RST_ZERO;
        if (wr_i) begin
            case (addr_i)
                `REG_GENERAL_CTRL: r_d.general = wdata_i;
                `REG_SERVICE_REQ:  r_d.service = wdata_i & `SR_USED_MASK;
                `REG_PORT_A_DIR:   r_d.dir_a   = wdata_i;
                `REG_PORT_B_DIR:   r_d.dir_b   = wdata_i;
                `REG_PORT_C_DIR:   r_d.dir_c   = wdata_i;
                `REG_VECTOR_BASE: begin
                    r_d.vector    = wdata_i & `VEC_MASK;
                    vec_written_d = 1'b1;
                end
                `REG_PORT_A_CTRL:  r_d.ctrl_a  = wdata_i;
                `REG_PORT_B_CTRL:  r_d.ctrl_b  = wdata_i;
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `REG_GENERAL_CTRL: r_d.rdata = r_q.general;
                `REG_SERVICE_REQ:  r_d.rdata = r_q.service;
                `REG_PORT_A_DIR:   r_d.rdata = r_q.dir_a;
                `REG_PORT_B_DIR:   r_d.rdata = r_q.dir_b;
                `REG_PORT_C_DIR:   r_d.rdata = r_q.dir_c;
                `REG_VECTOR_BASE:  r_d.rdata = r_q.vector;
                `REG_PORT_A_CTRL:  r_d.rdata = r_q.ctrl_a;
                `REG_PORT_B_CTRL:  r_d.rdata = r_q.ctrl_b;
                `REG_LATCH_STATUS: r_d.rdata = {status_flag_3_o, status_flag_1_o, 2'h0, latch_full_i};
                default:           r_d.rdata = `RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r_q.general   <= `RST_ZERO;
            r_q.service   <= `RST_ZERO;
            r_q.dir_a     <= `RST_ZERO;
            r_q.dir_b     <= `RST_ZERO;
            r_q.dir_c     <= `RST_ZERO;
            r_q.vector    <= `RST_VECTOR;
            r_q.ctrl_a    <= `RST_ZERO;
            r_q.ctrl_b    <= `RST_ZERO;
            r_q.rdata     <= `RST_ZERO;
            vec_written_q <= 1'b0;
        end else begin
            r_q           <= r_d;
            vec_written_q <= vec_written_d;
        end
    end

    logic [1:0] mode;
    assign mode = r_q.general[`GC_MODE_HI:`GC_MODE_LO];

    assign rdata_o     = r_q.rdata;
    assign port_mode_o = mode;
    assign pair_three_four_enable_o = r_q.general[`GC_PAIR34_BIT];
    assign pair_one_two_enable_o    = r_q.general[`GC_PAIR12_BIT];

    assign port_a_dir_eff_o = (mode == 2'h3) ? `RST_ZERO : r_q.dir_a;
    assign port_b_dir_eff_o = mode[1] ? `RST_ZERO : r_q.dir_b;
    assign port_c_dir_o     = r_q.dir_c;

    assign port_c_pin_five_irq_o = r_q.service[`SR_PINSEL_LO];
    assign port_c_pin_six_ack_o  = r_q.service[`SR_PINSEL_HI];
    assign service_select_o      = r_q.service[6:5];
    assign prio_order_o   = prio_decode(r_q.service[`SR_PRIO_HI:`SR_PRIO_LO]);
    assign vector_upper_o = r_q.vector[7:2];

    assign line_2_ctrl_o = line_decode(r_q.ctrl_a[`PC_LINE_HI:`PC_LINE_LO], mode, r_q.ctrl_a[`PC_SUB_HI:`PC_SUB_LO]);
    assign line_4_ctrl_o = line_decode(r_q.ctrl_b[`PC_LINE_HI:`PC_LINE_LO], mode, r_q.ctrl_b[`PC_SUB_HI:`PC_SUB_LO]);

    assign line_1_service_en_o = r_q.ctrl_a[`PC_SVC_BIT];
    assign line_2_irq_en_o     = r_q.ctrl_a[`PC_IRQ_BIT];
    assign line_3_service_en_o = r_q.ctrl_b[`PC_SVC_BIT];
    assign line_4_irq_en_o     = r_q.ctrl_b[`PC_IRQ_BIT];

    // Latch inputs: bit0 A initial, bit1 A final, bit2 B initial, bit3 B final.
    logic flag1_c;
    logic flag3_c;
    always_comb begin
        flag1_c = 1'b0;
        flag3_c = 1'b0;
        case (mode)
            2'h0: flag1_c = (r_q.ctrl_a[7:6] == 2'h1) &&
                            fill_flag(r_q.ctrl_a[`PC_STAT_BIT], latch_full_i, 4'h3);
            2'h2: flag1_c = fill_flag(r_q.ctrl_a[`PC_STAT_BIT], latch_full_i, 4'hc);
            2'h3: flag1_c = fill_flag(r_q.ctrl_a[`PC_STAT_BIT], latch_full_i, 4'hf);
            default: flag1_c = 1'b0;
        endcase
        if (mode == 2'h0 && r_q.ctrl_b[7:6] == 2'h1) begin
            flag3_c = fill_flag(r_q.ctrl_b[`PC_STAT_BIT], latch_full_i, 4'hc);
        end else if (mode == 2'h1 && r_q.ctrl_b[6]) begin
            flag3_c = fill_flag(r_q.ctrl_b[`PC_STAT_BIT], latch_full_i, 4'hf);
        end
    end
    assign status_flag_1_o = flag1_c;
    assign status_flag_3_o = flag3_c;

    vector_reset_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!vec_written_q && $past(rd_i) && $past(addr_i) == `REG_VECTOR_BASE && !$past(rst_i))
        |-> rdata_o == 8'h0f) else $error("vector not 0f before write");
    vector_mask_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_VECTOR_BASE) ##1 (rd_i && addr_i == `REG_VECTOR_BASE && !wr_i)
        |=> rdata_o == ($past(wdata_i, 2) & 8'hfc)) else $error("vector readback wrong");
    dir_a_ignore_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h3) |-> port_a_dir_eff_o == 8'h00) else $error("port A direction used in mode 3");
    dir_b_ignore_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode[1]) |-> port_b_dir_eff_o == 8'h00) else $error("port B direction used");
    dir_a_reset_a: assert property (@(posedge mclk_i)
        ($past(rst_i) && !rst_i) |-> (r_q.dir_a == 8'h00 && r_q.dir_c == 8'h00)) else $error("direction not cleared");
    line_bidir_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        mode[1] |-> (line_2_ctrl_o.out_en && line_2_ctrl_o.pulsed == r_q.ctrl_a[3])) else $error("line 2 not output");
    line_static_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h1 && r_q.ctrl_a[5]) |-> (line_2_ctrl_o.level == r_q.ctrl_a[3] && !line_2_ctrl_o.pulsed))
        else $error("line 2 static level wrong");
    flag_all_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h3 && r_q.ctrl_a[0]) |-> status_flag_1_o == (latch_full_i == 4'h0)) else $error("flag 1 mode 3 wrong");
    prio_top_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (r_q.service[2:0] == 3'h6) |-> prio_order_o == 8'he1) else $error("priority order wrong");

    dir_a_store_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_PORT_A_DIR) |=> r_q.dir_a == $past(wdata_i))
        else $error("port A direction not stored");
    dir_b_store_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_PORT_B_DIR) |=> r_q.dir_b == $past(wdata_i))
        else $error("port B direction not stored");
    dir_c_store_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_PORT_C_DIR) |=> port_c_dir_o == $past(wdata_i))
        else $error("port C direction not stored");
    dir_a_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode != 2'h3) |-> port_a_dir_eff_o == r_q.dir_a)
        else $error("port A direction not applied");
    dir_b_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!mode[1]) |-> port_b_dir_eff_o == r_q.dir_b)
        else $error("port B direction not applied");
    dir_c_reset_a: assert property (@(posedge mclk_i)
        ($past(rst_i) && !rst_i) |-> port_c_dir_o == 8'h00)
        else $error("port C direction not cleared");
    ctrl_a_reset_a: assert property (@(posedge mclk_i)
        ($past(rst_i) && !rst_i) |-> r_q.ctrl_a == 8'h00)
        else $error("port A control not cleared");
    ctrl_b_reset_a: assert property (@(posedge mclk_i)
        ($past(rst_i) && !rst_i) |-> r_q.ctrl_b == 8'h00)
        else $error("port B control not cleared");
    vec_reset_val_a: assert property (@(posedge mclk_i)
        ($past(rst_i) && !rst_i) |-> r_q.vector == 8'h0f)
        else $error("vector reset value wrong");
    vec_low_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        vec_written_q |-> r_q.vector[1:0] == 2'h0)
        else $error("vector low bits not zero");
    vec_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_VECTOR_BASE) |=> vector_upper_o == $past(wdata_i[7:2]))
        else $error("vector upper bits lost");
    read_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_i && !wr_i) |=> ($stable(r_q.vector) && $stable(vec_written_q)))
        else $error("vector read had a side effect");
    read_b_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_i && !wr_i) |=> $stable(r_q.ctrl_b))
        else $error("port B control read had a side effect");
    rdata_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!$past(rd_i)) |-> rdata_o == 8'h00)
        else $error("read data without read strobe");
    pin_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_SERVICE_REQ)
        |=> (port_c_pin_five_irq_o == $past(wdata_i[3]) && port_c_pin_six_ack_o == $past(wdata_i[4])))
        else $error("interrupt pin select wrong");
    prio_base_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (r_q.service[2:0] == 3'h0) |-> prio_order_o == 8'h1b)
        else $error("default priority order wrong");
    prio_swap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (r_q.service[2:0] == 3'h5) |-> prio_order_o == 8'hb4)
        else $error("priority order five wrong");
    gate_a_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_PORT_A_CTRL)
        |=> (line_1_service_en_o == $past(wdata_i[1]) && line_2_irq_en_o == $past(wdata_i[2])))
        else $error("port A request enables wrong");
    gate_b_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_PORT_B_CTRL)
        |=> (line_3_service_en_o == $past(wdata_i[1]) && line_4_irq_en_o == $past(wdata_i[2])))
        else $error("port B request enables wrong");
    line_in_hand_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h0 && r_q.ctrl_a[7:6] == 2'h0 && r_q.ctrl_a[5:4] == 2'h3)
        |-> (line_2_ctrl_o.out_en && !line_2_ctrl_o.output_type && line_2_ctrl_o.pulsed == r_q.ctrl_a[3]))
        else $error("line 2 input handshake wrong");
    line_out_hand_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h0 && r_q.ctrl_a[7:6] == 2'h1 && r_q.ctrl_a[5:4] == 2'h3)
        |-> (line_2_ctrl_o.out_en && line_2_ctrl_o.output_type && line_2_ctrl_o.interlocked == !r_q.ctrl_a[3]))
        else $error("line 2 output handshake wrong");
    line_input_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!mode[1] && !r_q.ctrl_a[5]) |-> !line_2_ctrl_o.out_en)
        else $error("line 2 driven while input");
    line_sub1x_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h0 && r_q.ctrl_a[7] && r_q.ctrl_a[5])
        |-> (line_2_ctrl_o.out_en && line_2_ctrl_o.level == r_q.ctrl_a[3] && !line_2_ctrl_o.interlocked))
        else $error("line 2 submode 1X level wrong");
    flag_a_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h0 && r_q.ctrl_a[7:6] == 2'h1 && !r_q.ctrl_a[0])
        |-> status_flag_1_o == (latch_full_i[1:0] != 2'h3))
        else $error("flag 1 mode 0 wrong");
    flag_b_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h2 && r_q.ctrl_a[0]) |-> status_flag_1_o == (latch_full_i[3:2] == 2'h0))
        else $error("flag 1 mode 2 wrong");
    flag_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mode == 2'h1) |-> !status_flag_1_o)
        else $error("flag 1 set in mode 1");
    mode_field_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_GENERAL_CTRL) |=> port_mode_o == $past(wdata_i[7:6]))
        else $error("port mode not taken");
    pair_bits_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_i && addr_i == `REG_GENERAL_CTRL)
        |=> (pair_three_four_enable_o == $past(wdata_i[5]) && pair_one_two_enable_o == $past(wdata_i[4])))
        else $error("pair enables not taken");

endmodule

`default_nettype wire

/* File: sim/latch_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Far-side handshake logic: latch fill follows the bench request one edge later.
// The flag lines keep moving every cycle, so a design that wrongly depended on them would show it.
module latch_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] fill_i,
    output logic      [3:0] latch_full_o,
    output logic      [3:0] flags_o
);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            latch_full_o <= 4'h0;
            flags_o      <= 4'h0;
        end else begin
            latch_full_o <= fill_i;
            flags_o      <= flags_o + 4'h1;
        end
    end
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "port_config_cfg.svh"

module tb_top;
    logic       mclk_i = 1'b0;
    logic       rst_i  = 1'b1;
    logic [4:0] addr   = 5'h00;
    logic [7:0] wdata  = 8'h00;
    logic       wr     = 1'b0;
    logic       rd     = 1'b0;
    logic [3:0] fill   = 4'h0;
    logic [7:0] rdata, dir_a, dir_b, dir_c, prio;
    logic [3:0] latch_full, flags;
    logic [1:0] mode_o, m;
    logic [5:0] vec;
    logic       en12, en34, pin5, pin6, s1e, i2e, s3e, i4e, f1, f3;
    port_config_pkg::line_ctrl_type l2, l4;
    int         errors = 0;
    int         samples_checked = 0;
    int         i, k, j;
    localparam logic [7:0] prio_tbl [8] = '{8'h1b, 8'h4b, 8'h1e, 8'h4e, 8'hb1, 8'hb4, 8'he1, 8'he4};
    localparam logic [7:0] lg [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h80, 8'hc0};
    localparam logic [7:0] lc [9] = '{8'h00, 8'h20, 8'h28, 8'h30, 8'h78, 8'hb8, 8'h30, 8'h00, 8'h08};
    localparam logic [4:0] lm [9] = '{5'h16, 5'h1e, 5'h1e, 5'h17, 5'h17, 5'h1e, 5'h1e, 5'h17, 5'h17};
    localparam logic [4:0] lv [9] = '{5'h00, 5'h10, 5'h18, 5'h14, 5'h13, 5'h18, 5'h10, 5'h15, 5'h13};

    always #5 mclk_i = ~mclk_i;

    latch_model far_u (.mclk_i(mclk_i), .rst_i(rst_i), .fill_i(fill), .latch_full_o(latch_full), .flags_o(flags));

    port_config dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .status_flags_i(flags), .latch_full_i(latch_full), .port_mode_o(mode_o),
        .pair_one_two_enable_o(en12), .pair_three_four_enable_o(en34), .port_a_dir_eff_o(dir_a),
        .port_b_dir_eff_o(dir_b), .port_c_dir_o(dir_c), .port_c_pin_five_irq_o(pin5),
        .port_c_pin_six_ack_o(pin6), .service_select_o(), .prio_order_o(prio), .vector_upper_o(vec),
        .line_2_ctrl_o(l2), .line_4_ctrl_o(l4), .line_1_service_en_o(s1e), .line_2_irq_en_o(i2e),
        .line_3_service_en_o(s3e), .line_4_irq_en_o(i4e), .status_flag_1_o(f1), .status_flag_3_o(f3)
    );

    task automatic test_done;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask

    // Write and read back to back, with no idle cycle between the strobes.
    task automatic wrrd(input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        chk("rdata_b2b", exp, rdata);
    endtask

    // Flag is set when the selected latches can take data, or only when all of them are empty.
    function automatic logic ok(input logic sel, input logic [3:0] full, input logic [3:0] used);
        return sel ? ((full & used) == 4'h0) : ((full & used) != used);
    endfunction

    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        test_done;
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 8; i++) begin
            rreg(5'(i), (i == 5) ? `RST_VECTOR : `RST_ZERO);
        end
        rreg(`REG_VECTOR_BASE, `RST_VECTOR);
        @(posedge mclk_i);
        #1;
        chk("rdata_idle", 8'h00, rdata);
        wrrd(`REG_VECTOR_BASE, 8'hab, 8'ha8);
        chk("vector_upper", 8'h2a, {2'b00, vec});
        wreg(5'h1f, 8'hff);
        rreg(5'h1f, 8'h00);
        // General control goes last so that submodes never change while a pair is enabled.
        for (i = 0; i < 8; i++) begin
            wreg(5'((i + 1) % 8), 8'hff);
            rreg(5'((i + 1) % 8), (i == 0) ? 8'h7f : (i == 4) ? 8'hfc : 8'hff);
        end
        for (k = 0; k < 32; k++) begin
            wreg(`REG_SERVICE_REQ, 8'(k));
            chk("pin_five", {7'h00, k[3]}, {7'h00, pin5});
            chk("pin_six", {7'h00, k[4]}, {7'h00, pin6});
            chk("prio", prio_tbl[k % 8], prio);
        end
        wreg(`REG_PORT_A_DIR, 8'ha5);
        wreg(`REG_PORT_B_DIR, 8'h3c);
        wreg(`REG_PORT_C_DIR, 8'h96);
        for (k = 0; k < 4; k++) begin
            m = 2'(k);
            wreg(`REG_GENERAL_CTRL, {m, m, 4'h0});
            chk("mode", {6'h00, m}, {6'h00, mode_o});
            chk("pairs", {6'h00, m}, {6'h00, en34, en12});
            chk("dir_a", (k == 3) ? 8'h00 : 8'ha5, dir_a);
            chk("dir_b", (k >= 2) ? 8'h00 : 8'h3c, dir_b);
            chk("dir_c", 8'h96, dir_c);
        end
        // Pairs off before any control write.
        wreg(`REG_GENERAL_CTRL, 8'h00);
        for (k = 0; k < 4; k++) begin
            wreg(`REG_PORT_A_CTRL, {5'h00, k[1:0], 1'b0});
            wreg(`REG_PORT_B_CTRL, {5'h00, k[1:0], 1'b0});
            chk("svc_en", {6'h00, k[0], k[0]}, {6'h00, s1e, s3e});
            chk("irq_en", {6'h00, k[1], k[1]}, {6'h00, i2e, i4e});
        end
        for (i = 0; i < 9; i++) begin
            wreg(`REG_GENERAL_CTRL, lg[i]);
            wreg(`REG_PORT_A_CTRL, lc[i]);
            wreg(`REG_PORT_B_CTRL, lc[i]);
            chk("line_2", {3'h0, lv[i]}, {3'h0, 5'(l2) & lm[i]});
            if (i < 6) begin
                chk("line_4", {3'h0, lv[i]}, {3'h0, 5'(l4) & lm[i]});
            end
        end
        for (j = 0; j < 6; j++) begin
            m = (j < 2) ? 2'h0 : (j < 4) ? 2'h2 : 2'h3;
            wreg(`REG_GENERAL_CTRL, {m, 6'h00});
            wreg(`REG_PORT_A_CTRL, {7'h20, j[0]});
            wreg(`REG_PORT_B_CTRL, {7'h20, j[0]});
            for (k = 0; k < 16; k++) begin
                @(posedge mclk_i);
                fill <= 4'(k);
                @(posedge mclk_i);
                #1;
                chk("flag_1", {7'h00, ok(j[0], 4'(k), (m == 2'h0) ? 4'h3 : (m == 2'h2) ? 4'hc : 4'hf)},
                    {7'h00, f1});
                chk("flag_3", {7'h00, (m == 2'h0) && ok(j[0], 4'(k), 4'hc)}, {7'h00, f3});
            end
        end
        test_done;
    end
endmodule

`default_nettype wire
